// File: core/hmc_regs.vh
// Byte offsets, fixed codes and reset values of the media control register bank.
// Assumes one 8-bit register byte per offset; multi-byte fields are stored high byte first.
`ifndef HMC_REGS_VH
`define HMC_REGS_VH

`define HMC_OFS_KEY_CODE      8'h4F
`define HMC_OFS_AUD_CMD       8'h50
`define HMC_OFS_AUD_TRACK     8'h51
`define HMC_OFS_AUD_VOL_REQ   8'h53
`define HMC_OFS_AUD_VOL       8'h54
`define HMC_OFS_AUD_STATE     8'h55
`define HMC_OFS_DB_REQ        8'h56
`define HMC_OFS_DB_DIR        8'h57
`define HMC_OFS_DB_START      8'h58
`define HMC_OFS_VAR_START     8'h5C
`define HMC_OFS_DB_COUNT      8'h5E
`define HMC_OFS_VID_REQ       8'h60
`define HMC_OFS_VID_TYPE      8'h61
`define HMC_OFS_VID_POS       8'h62
`define HMC_OFS_VID_TRACK     8'h66
`define HMC_OFS_VID_VOL_REQ   8'h68
`define HMC_OFS_VID_VOL       8'h69
`define HMC_OFS_VID_PLAY      8'h6A
`define HMC_OFS_VID_HALT      8'h6B
`define HMC_OFS_VID_NEXT      8'h6C
`define HMC_OFS_VID_STATE     8'h6D
`define HMC_OFS_CAL_TRIG      8'hEA
`define HMC_OFS_CURVE_CLR     8'hEB
`define HMC_OFS_SW_RESET      8'hEE
`define HMC_OFS_TOUCH_ENTRY   8'hF9

`define HMC_CODE_APPLY        8'h5A
`define HMC_CODE_AUD_PLAY     8'h5B
`define HMC_CODE_AUD_STOP     8'h5C
`define HMC_CODE_DIR_TO_DB    8'h50
`define HMC_CODE_DIR_FROM_DB  8'hA0
`define HMC_CODE_CURVE_ALL    8'h55
`define HMC_CODE_CURVE_CH0    8'h56
`define HMC_CODE_CURVE_CH7    8'h5D
`define HMC_CODE_SW_RESET     16'h5AA5
`define HMC_VID_SRC_INTERNAL  8'h00
`define HMC_VID_SRC_REMOVABLE 8'h01
`define HMC_VID_SRC_SEQUENCE  8'h02

`define HMC_RST_AUD_VOL       8'h40
`define HMC_RST_VID_VOL       8'h3F
`define HMC_AUD_VOL_MAX       8'h40
`define HMC_VID_VOL_MAX       8'h3F
`define HMC_AUD_TRACK_MAX     16'h0FFF

`endif

// File: core/hmc_trigger.v
// One self-clearing request byte with a start pulse and a busy flag.
// Assumes the parent qualifies fire with the documented code and the engine answers with done.
`default_nettype none

module hmc_trigger (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire       fire,
    input  wire       done,
    output reg  [7:0] value,
    output reg        start,
    output reg        busy
);

    always @(posedge clk_sys) begin
        if (rst) begin
            value <= 8'h00;
            start <= 1'b0;
            busy  <= 1'b0;
        end else begin
            start <= fire & ~busy;
            if (fire && !busy) begin
                busy <= 1'b1;
            end else if (done) begin
                busy <= 1'b0;
            end
            // A host write in the cycle of done wins, so a fresh request is never lost.
            if (wr_en) begin
                value <= wr_data;
            end else if (done && busy) begin
                value <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

// File: core/hmc_media_regs.v
// Upper media control register bank: key, audio, database, video, touch and reset triggers.
// Assumes a serial command decoder delivers byte reads and writes and marks each write
// command's end with cmd_end, and that media engines answer requests with done strobes.
`include "hmc_regs.vh"
`default_nettype none

module hmc_media_regs (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        cmd_end,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    output wire [7:0]  key_code,
    output wire        key_fire,
    input  wire        key_done,
    output reg         audio_play,
    output reg         audio_stop,
    output reg  [15:0] audio_track,
    output reg  [7:0]  audio_volume,
    input  wire        audio_playing,
    output wire        db_start,
    output reg         db_to_database,
    output reg  [31:0] db_start_word,
    output reg  [15:0] db_var_word,
    output reg  [15:0] db_word_count,
    input  wire        db_done,
    output wire        video_start,
    output reg  [7:0]  video_source,
    output reg  [15:0] video_x,
    output reg  [15:0] video_y,
    output reg         video_centre,
    output reg  [15:0] video_track,
    input  wire        video_done,
    output reg  [7:0]  video_volume,
    output reg         video_toggle,
    output reg         video_halt,
    output reg         video_next,
    input  wire [1:0]  video_state,
    input  wire        touch_entry_active,
    output reg         touch_exit,
    output wire        cal_start,
    input  wire        cal_done,
    output wire        curve_start,
    output reg  [7:0]  curve_channels,
    input  wire        curve_done,
    output reg         soft_reset
);

    reg  [15:0] aud_track_reg;
    reg  [7:0]  aud_cmd_reg;
    reg  [7:0]  aud_vol_req;
    reg  [7:0]  aud_vol_reg;
    reg  [7:0]  db_dir_reg;
    reg  [31:0] db_start_reg;
    reg  [15:0] var_start_reg;
    reg  [15:0] db_count_reg;
    reg  [7:0]  vid_type_reg;
    reg  [31:0] vid_pos_reg;
    reg  [15:0] vid_track_reg;
    reg  [7:0]  vid_vol_req;
    reg  [7:0]  vid_vol_reg;
    reg  [7:0]  vid_play_reg;
    reg  [7:0]  vid_halt_reg;
    reg  [7:0]  vid_next_reg;
    reg  [15:0] sw_reset_reg;
    reg         in_sequence;
    reg  [7:0]  next_rdata;
    wire        rst_all;
    wire [7:0]  db_req;
    wire [7:0]  vid_req;
    wire [7:0]  cal_req;
    wire [7:0]  curve_req;
    wire        key_busy;
    wire        db_busy;
    wire        vid_busy;
    wire        cal_busy;
    wire        curve_busy;
    wire        db_fire;
    wire        vid_fire;
    wire        curve_fire;
    wire        key_go;

    // The software reset also returns this bank to its power-up values.
    assign rst_all = rst | soft_reset;

    function wr_at;
        input       we;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_at = we && (addr == ofs);
        end
    endfunction

    // Replaces one byte of a big-endian multi-byte field; idx 0 is the high byte.
    function [31:0] put_byte;
        input [31:0] old;
        input [1:0]  idx;
        input [7:0]  data;
        reg   [31:0] tmp;
        begin
            tmp = old;
            tmp[8 * (3 - idx) +: 8] = data;
            put_byte = tmp;
        end
    endfunction

    function in_field;
        input [7:0] addr;
        input [7:0] base;
        input [2:0] len;
        begin
            in_field = (addr >= base) && (addr < base + {5'h00, len});
        end
    endfunction

    function [7:0] curve_mask;
        input [7:0] code;
        begin
            if (code == `HMC_CODE_CURVE_ALL) begin
                curve_mask = 8'hFF;
            end else if (code >= `HMC_CODE_CURVE_CH0 && code <= `HMC_CODE_CURVE_CH7) begin
                curve_mask = 8'h01 << (code - `HMC_CODE_CURVE_CH0);
            end else begin
                curve_mask = 8'h00;
            end
        end
    endfunction

    // Requests act only once the whole write command has landed, so the
    // parameters written after the trigger byte in the same command are used.
    assign key_go     = cmd_end && (key_code != 8'h00);
    assign db_fire    = cmd_end && (db_req == `HMC_CODE_APPLY) && (db_count_reg != 16'h0000)
                        && (db_dir_reg == `HMC_CODE_DIR_TO_DB
                            || db_dir_reg == `HMC_CODE_DIR_FROM_DB);
    assign vid_fire   = cmd_end && (vid_req == `HMC_CODE_APPLY)
                        && (vid_type_reg <= `HMC_VID_SRC_SEQUENCE);
    assign curve_fire = cmd_end && (curve_mask(curve_req) != 8'h00);

    hmc_trigger u_key (
        .clk_sys (clk_sys),
        .rst     (rst_all),
        .wr_en   (wr_at(reg_wr, reg_addr, `HMC_OFS_KEY_CODE)),
        .wr_data (reg_wdata),
        .fire    (key_go),
        .done    (key_done),
        .value   (key_code),
        .start   (key_fire),
        .busy    (key_busy)
    );

    hmc_trigger u_db (
        .clk_sys (clk_sys),
        .rst     (rst_all),
        .wr_en   (wr_at(reg_wr, reg_addr, `HMC_OFS_DB_REQ)),
        .wr_data (reg_wdata),
        .fire    (db_fire),
        .done    (db_done),
        .value   (db_req),
        .start   (db_start),
        .busy    (db_busy)
    );

    hmc_trigger u_vid (
        .clk_sys (clk_sys),
        .rst     (rst_all),
        .wr_en   (wr_at(reg_wr, reg_addr, `HMC_OFS_VID_REQ)),
        .wr_data (reg_wdata),
        .fire    (vid_fire),
        .done    (video_done),
        .value   (vid_req),
        .start   (video_start),
        .busy    (vid_busy)
    );

    hmc_trigger u_cal (
        .clk_sys (clk_sys),
        .rst     (rst_all),
        .wr_en   (wr_at(reg_wr, reg_addr, `HMC_OFS_CAL_TRIG)),
        .wr_data (reg_wdata),
        .fire    (cmd_end && cal_req == `HMC_CODE_APPLY),
        .done    (cal_done),
        .value   (cal_req),
        .start   (cal_start),
        .busy    (cal_busy)
    );

    hmc_trigger u_curve (
        .clk_sys (clk_sys),
        .rst     (rst_all),
        .wr_en   (wr_at(reg_wr, reg_addr, `HMC_OFS_CURVE_CLR)),
        .wr_data (reg_wdata),
        .fire    (curve_fire),
        .done    (curve_done),
        .value   (curve_req),
        .start   (curve_start),
        .busy    (curve_busy)
    );

    // Host byte writes into the parameter and one-shot bytes.
    always @(posedge clk_sys) begin
        if (rst_all) begin
            aud_cmd_reg   <= 8'h00;
            aud_track_reg <= 16'h0000;
            aud_vol_req   <= 8'h00;
            aud_vol_reg   <= `HMC_RST_AUD_VOL;
            db_dir_reg    <= 8'h00;
            db_start_reg  <= 32'h0000_0000;
            var_start_reg <= 16'h0000;
            db_count_reg  <= 16'h0000;
            vid_type_reg  <= `HMC_VID_SRC_INTERNAL;
            vid_pos_reg   <= 32'h0000_0000;
            vid_track_reg <= 16'h0000;
            vid_vol_req   <= 8'h00;
            vid_vol_reg   <= `HMC_RST_VID_VOL;
            vid_play_reg  <= 8'h00;
            vid_halt_reg  <= 8'h00;
            vid_next_reg  <= 8'h00;
            sw_reset_reg  <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `HMC_OFS_AUD_CMD) aud_cmd_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_AUD_TRACK) aud_track_reg[15:8] <= reg_wdata;
            if (reg_addr == `HMC_OFS_AUD_TRACK + 8'h01) aud_track_reg[7:0] <= reg_wdata;
            if (reg_addr == `HMC_OFS_AUD_VOL_REQ) aud_vol_req <= reg_wdata;
            if (reg_addr == `HMC_OFS_AUD_VOL) aud_vol_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_DB_DIR) db_dir_reg <= reg_wdata;
            if (in_field(reg_addr, `HMC_OFS_DB_START, 3'd4)) begin
                db_start_reg <= put_byte(db_start_reg, reg_addr[1:0], reg_wdata);
            end
            if (reg_addr == `HMC_OFS_VAR_START) var_start_reg[15:8] <= reg_wdata;
            if (reg_addr == `HMC_OFS_VAR_START + 8'h01) var_start_reg[7:0] <= reg_wdata;
            if (reg_addr == `HMC_OFS_DB_COUNT) db_count_reg[15:8] <= reg_wdata;
            if (reg_addr == `HMC_OFS_DB_COUNT + 8'h01) db_count_reg[7:0] <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_TYPE) vid_type_reg <= reg_wdata;
            if (in_field(reg_addr, `HMC_OFS_VID_POS, 3'd4)) begin
                vid_pos_reg <= put_byte(vid_pos_reg, reg_addr[1:0] - 2'd2, reg_wdata);
            end
            if (reg_addr == `HMC_OFS_VID_TRACK) vid_track_reg[15:8] <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_TRACK + 8'h01) vid_track_reg[7:0] <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_VOL_REQ) vid_vol_req <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_VOL) vid_vol_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_PLAY) vid_play_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_HALT) vid_halt_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_VID_NEXT) vid_next_reg <= reg_wdata;
            if (reg_addr == `HMC_OFS_SW_RESET) sw_reset_reg[15:8] <= reg_wdata;
            if (reg_addr == `HMC_OFS_SW_RESET + 8'h01) sw_reset_reg[7:0] <= reg_wdata;
        end else if (cmd_end) begin
            // One-shot bytes are consumed by the command end whatever they held.
            aud_cmd_reg  <= 8'h00;
            aud_vol_req  <= 8'h00;
            vid_vol_req  <= 8'h00;
            vid_play_reg <= 8'h00;
            vid_halt_reg <= 8'h00;
            vid_next_reg <= 8'h00;
            sw_reset_reg <= 16'h0000;
        end
    end

    // Actions started at the end of a write command; the touch exit starts on its own byte write.
    always @(posedge clk_sys) begin
        if (rst_all) begin
            audio_play     <= 1'b0;
            audio_stop     <= 1'b0;
            audio_track    <= 16'h0000;
            audio_volume   <= `HMC_RST_AUD_VOL;
            video_volume   <= `HMC_RST_VID_VOL;
            video_toggle   <= 1'b0;
            video_halt     <= 1'b0;
            video_next     <= 1'b0;
            touch_exit     <= 1'b0;
            db_to_database <= 1'b0;
            db_start_word  <= 32'h0000_0000;
            db_var_word    <= 16'h0000;
            db_word_count  <= 16'h0000;
            video_source   <= `HMC_VID_SRC_INTERNAL;
            video_x        <= 16'h0000;
            video_y        <= 16'h0000;
            video_centre   <= 1'b1;
            video_track    <= 16'h0000;
            in_sequence    <= 1'b0;
            curve_channels <= 8'h00;
        end else begin
            audio_play   <= cmd_end && aud_cmd_reg == `HMC_CODE_AUD_PLAY
                            && aud_track_reg <= `HMC_AUD_TRACK_MAX;
            audio_stop   <= cmd_end && aud_cmd_reg == `HMC_CODE_AUD_STOP;
            video_toggle <= cmd_end && vid_play_reg == `HMC_CODE_APPLY;
            // Next in a single-play mode ends the video rather than advancing.
            video_next   <= cmd_end && vid_next_reg == `HMC_CODE_APPLY && in_sequence;
            video_halt   <= cmd_end && (vid_halt_reg == `HMC_CODE_APPLY
                            || (vid_next_reg == `HMC_CODE_APPLY && !in_sequence));
            touch_exit   <= wr_at(reg_wr, reg_addr, `HMC_OFS_TOUCH_ENTRY)
                            && reg_wdata == 8'h00 && touch_entry_active;
            if (cmd_end && aud_cmd_reg == `HMC_CODE_AUD_PLAY
                && aud_track_reg <= `HMC_AUD_TRACK_MAX) begin
                audio_track <= aud_track_reg;
            end
            if (cmd_end && aud_vol_req == `HMC_CODE_APPLY
                && aud_vol_reg <= `HMC_AUD_VOL_MAX) begin
                audio_volume <= aud_vol_reg;
            end
            if (cmd_end && vid_vol_req == `HMC_CODE_APPLY
                && vid_vol_reg <= `HMC_VID_VOL_MAX) begin
                video_volume <= vid_vol_reg;
            end
            // Transfer parameters are latched so the host may reload them meanwhile.
            if (db_fire && !db_busy) begin
                db_to_database <= (db_dir_reg == `HMC_CODE_DIR_TO_DB);
                db_start_word  <= db_start_reg;
                db_var_word    <= var_start_reg;
                db_word_count  <= db_count_reg;
            end
            if (vid_fire && !vid_busy) begin
                video_source <= vid_type_reg;
                video_x      <= vid_pos_reg[31:16];
                video_y      <= vid_pos_reg[15:0];
                video_centre <= (vid_pos_reg == 32'h0000_0000);
                in_sequence  <= (vid_type_reg == `HMC_VID_SRC_SEQUENCE);
                video_track  <= (vid_type_reg == `HMC_VID_SRC_SEQUENCE)
                                ? 16'h0000 : vid_track_reg;
            end
            if (curve_fire && !curve_busy) begin
                curve_channels <= curve_mask(curve_req);
            end
        end
    end

    // Software reset pulses for one cycle; it uses only the plain reset so it ends.
    always @(posedge clk_sys) begin
        if (rst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= cmd_end && !soft_reset && sw_reset_reg == `HMC_CODE_SW_RESET;
        end
    end

    // Write-only bytes and multi-byte parameter fields read back as zero; direction and source type read their stored value, volumes the applied one.
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `HMC_OFS_AUD_STATE:   next_rdata = {7'h00, audio_playing};
            `HMC_OFS_DB_REQ:      next_rdata = db_req;
            `HMC_OFS_VID_REQ:     next_rdata = vid_req;
            `HMC_OFS_VID_STATE:   next_rdata = {6'h00, video_state};
            `HMC_OFS_TOUCH_ENTRY: next_rdata = {7'h00, touch_entry_active};
            `HMC_OFS_KEY_CODE:    next_rdata = key_code;
            `HMC_OFS_CAL_TRIG:    next_rdata = cal_req;
            `HMC_OFS_CURVE_CLR:   next_rdata = curve_req;
            `HMC_OFS_DB_DIR:      next_rdata = db_dir_reg;
            `HMC_OFS_VID_TYPE:    next_rdata = vid_type_reg;
            `HMC_OFS_AUD_VOL:     next_rdata = audio_volume;
            `HMC_OFS_VID_VOL:     next_rdata = video_volume;
            default:              next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst_all) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule

`default_nettype wire

// File: verification/hmc_media_regs_checker.sv
// Port-level checks of the media register bank.
// Assumes the single clk_sys domain and its synchronous active-high reset.
`default_nettype none
module hmc_media_regs_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_rd,
    input wire logic        reg_rvalid,
    input wire logic        cmd_end,
    input wire logic [7:0]  key_code,
    input wire logic        key_fire,
    input wire logic        audio_play,
    input wire logic [15:0] audio_track,
    input wire logic [7:0]  audio_volume,
    input wire logic        db_start,
    input wire logic [15:0] db_word_count,
    input wire logic [7:0]  video_volume,
    input wire logic        video_centre,
    input wire logic        touch_entry_active,
    input wire logic        touch_exit,
    input wire logic        soft_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_bank_reset;
        audio_volume == 8'h40 && video_volume == 8'h3F && video_centre;
    endsequence
    sequence s_soft_done;
        !soft_reset ##0 s_bank_reset;
    endsequence
    property p_rd; reg_rd |=> reg_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_key; key_fire |-> $past(cmd_end) && key_code != 8'h00; endproperty
    a_key: assert property (p_key) else $error("bad key action");
    property p_aud; audio_play |-> $past(cmd_end) && audio_track <= 16'h0FFF; endproperty
    a_aud: assert property (p_aud) else $error("bad audio play");
    property p_db; db_start |-> $past(cmd_end) && db_word_count != 16'h0000; endproperty
    a_db: assert property (p_db) else $error("bad transfer start");
    property p_avol; audio_volume <= 8'h40 && video_volume <= 8'h3F; endproperty
    a_avol: assert property (p_avol) else $error("volume out of range");
    property p_rst; $fell(rst) |-> s_bank_reset; endproperty
    a_rst: assert property (p_rst) else $error("wrong reset volumes");
    property p_soft; soft_reset |=> s_soft_done; endproperty
    a_soft: assert property (p_soft) else $error("soft reset incomplete");
    property p_touch; touch_exit |-> $past(touch_entry_active); endproperty
    a_touch: assert property (p_touch) else $error("exit outside entry");
endmodule
`default_nettype wire

// File: verification/hmc_engine_model.sv
// Behavioural media engines: each answers a start pulse with one done pulse.
// Assumes starts are one-cycle pulses; every engine stays busy LAT cycles.
`default_nettype none
module hmc_engine_model #(
    parameter int LAT = 20
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [4:0] start,
    output var  logic [4:0] done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [5];
    // A slow answer keeps each request busy long enough for a retry to be refused.
    always @(posedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            done[i] <= !rst && cnt[i] == 1;
            if (rst) begin
                cnt[i] <= 0;
            end else if (start[i]) begin
                cnt[i] <= LAT;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/hmc_media_regs_tb_top.sv
// Self-checking bench of the media register bank through its byte register port.
// Assumes actions fire one cycle after cmd_end and engines answer 21 cycles after each start.
`default_nettype none
module hmc_media_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_end = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic        audio_playing = 1'b0, touch_entry_active = 1'b0;
    logic [1:0]  video_state = 2'h0;
    logic        key_done, db_done, video_done, cal_done, curve_done, reg_rvalid, seen;
    logic        key_fire, db_start, video_start, cal_start, curve_start, soft_reset;
    logic        audio_play, audio_stop, video_toggle, video_halt, video_next, touch_exit;
    logic        db_to_database, video_centre;
    logic [7:0]  reg_rdata, key_code, audio_volume, video_source, video_volume, curve_channels;
    logic [15:0] audio_track, db_var_word, db_word_count, video_x, video_y, video_track;
    logic [31:0] db_start_word;
    logic [11:0] pv;
    int          err_count = 0;
    int          checks_done = 0;
    assign pv = {audio_play, audio_stop, key_fire, db_start, video_start, video_toggle,
                 video_halt, video_next, cal_start, curve_start, soft_reset, touch_exit};
    always #25 clk_sys = ~clk_sys;
    hmc_media_regs uut (
        .clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .cmd_end, .reg_rdata,
        .reg_rvalid, .key_code, .key_fire, .key_done, .audio_play, .audio_stop, .audio_track,
        .audio_volume, .audio_playing, .db_start, .db_to_database, .db_start_word,
        .db_var_word, .db_word_count, .db_done, .video_start, .video_source, .video_x,
        .video_y, .video_centre, .video_track, .video_done, .video_volume, .video_toggle,
        .video_halt, .video_next, .video_state, .touch_entry_active, .touch_exit, .cal_start,
        .cal_done, .curve_start, .curve_channels, .curve_done, .soft_reset
    );
    hmc_engine_model eng (
        .clk_sys, .rst,
        .start({key_fire, db_start, video_start, cal_start, curve_start}),
        .done({key_done, db_done, video_done, cal_done, curve_done})
    );
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Strobes stay high between back-to-back accesses so no signal is set twice per step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd = 1'b0;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
    endtask
    task automatic wr2(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h01, d[7:0]);
    endtask
    task automatic go();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmd_end = 1'b1;
        step();
        cmd_end = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        step();
        chk($sformatf("read %h", a), 32'({reg_rvalid, reg_rdata}), 32'({1'b1, e}));
    endtask
    task automatic trig(input logic [7:0] a, input logic [7:0] d, input logic [11:0] e);
        wr(a, d);
        go();
        chk($sformatf("pulses %h", a), 32'(pv), 32'(e));
    endtask
    task automatic vol(input logic [7:0] a, input logic [7:0] q, input logic [7:0] v,
                       input logic [7:0] e);
        wr(a, q);
        wr(a + 8'h01, v);
        go();
        rd(a + 8'h01, e);
    endtask
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (5) step();
        rst = 1'b0;
        rd(8'h54, 8'h40);
        rd(8'h69, 8'h3F);
        rd(8'h70, 8'h00);
        audio_playing = 1'b1;
        rd(8'h55, 8'h01);
        audio_playing = 1'b0;
        rd(8'h55, 8'h00);
        wr2(8'h51, 16'h0006);
        trig(8'h50, 8'h5B, 12'h800);
        chk("track", 32'(audio_track), 32'h00000006);
        trig(8'h50, 8'h5C, 12'h400);
        wr2(8'h51, 16'h1000);
        trig(8'h50, 8'h5B, 12'h000);
        chk("track kept", 32'(audio_track), 32'h00000006);
        vol(8'h53, 8'h5A, 8'h20, 8'h20);
        vol(8'h53, 8'h5A, 8'h41, 8'h20);
        vol(8'h53, 8'h5B, 8'h10, 8'h20);
        vol(8'h68, 8'h5A, 8'h11, 8'h11);
        vol(8'h68, 8'h5A, 8'h40, 8'h11);
        trig(8'h4F, 8'h07, 12'h200);
        chk("key", 32'(key_code), 32'h00000007);
        repeat (25) step();
        chk("key clear", 32'(key_code), 32'h00000000);
        trig(8'h4F, 8'h00, 12'h000);
        for (int i = 0; i < 2; i++) begin
            wr(8'h57, i == 0 ? 8'h50 : 8'hA0);
            wr2(8'h58, 16'h0001);
            wr2(8'h5A, 16'h2345);
            wr2(8'h5C, 16'h0100);
            wr2(8'h5E, 16'h0010);
            trig(8'h56, 8'h5A, 12'h100);
            chk("dir", 32'(db_to_database), 32'(i == 0));
            chk("db word", db_start_word, 32'h00012345);
            chk("var count", {db_var_word, db_word_count}, 32'h01000010);
            trig(8'h56, 8'h5A, 12'h000);
            repeat (25) step();
            rd(8'h56, 8'h00);
        end
        wr2(8'h5E, 16'h0000);
        trig(8'h56, 8'h5A, 12'h000);
        for (int t = 0; t < 3; t++) begin
            wr(8'h61, 8'(t));
            wr2(8'h62, t == 2 ? 16'h0000 : 16'h0010);
            wr2(8'h64, t == 2 ? 16'h0000 : 16'h0020);
            wr2(8'h66, 16'h0009);
            trig(8'h60, 8'h5A, 12'h080);
            chk("source", 32'(video_source), t);
            chk("pos", {video_x, video_y}, t == 2 ? 32'h00000000 : 32'h00100020);
            chk("centre", 32'(video_centre), 32'(t == 2));
            chk("vtrack", 32'(video_track), t == 2 ? 32'h00000000 : 32'h00000009);
            trig(8'h6C, 8'h5A, t == 2 ? 12'h010 : 12'h020);
            repeat (25) step();
            rd(8'h60, 8'h00);
        end
        wr(8'h61, 8'h03);
        trig(8'h60, 8'h5A, 12'h000);
        wr(8'h60, 8'h00);
        trig(8'h6A, 8'h5A, 12'h040);
        trig(8'h6B, 8'h5A, 12'h020);
        trig(8'h6C, 8'h5A, 12'h010);
        trig(8'h6C, 8'h5B, 12'h000);
        for (int s = 0; s < 3; s++) begin
            video_state = 2'(s);
            rd(8'h6D, 8'(s));
        end
        touch_entry_active = 1'b1;
        rd(8'hF9, 8'h01);
        wr(8'hF9, 8'h00);
        seen = touch_exit;
        go();
        chk("touch exit", 32'(seen | touch_exit), 32'h00000001);
        trig(8'hEA, 8'h5A, 12'h008);
        trig(8'hEB, 8'h55, 12'h004);
        chk("curves", 32'(curve_channels), 32'h000000FF);
        repeat (25) step();
        trig(8'hEB, 8'h59, 12'h004);
        chk("curves", 32'(curve_channels), 32'h00000008);
        repeat (25) step();
        trig(8'hEB, 8'h5E, 12'h000);
        wr(8'hEE, 8'h5A);
        trig(8'hEF, 8'hA4, 12'h000);
        wr(8'hEE, 8'h5A);
        trig(8'hEF, 8'hA5, 12'h002);
        step();
        rd(8'h54, 8'h40);
        finish_test();
    end
endmodule
bind hmc_media_regs hmc_media_regs_checker u_chk (
    .clk_sys, .rst, .reg_rd, .reg_rvalid, .cmd_end, .key_code, .key_fire, .audio_play,
    .audio_track, .audio_volume, .db_start, .db_word_count, .video_volume, .video_centre,
    .touch_entry_active, .touch_exit, .soft_reset
);
`default_nettype wire
